// ===== rtl/irpb_ctrl.sv
// Pattern-burst engine with its control, timing and status registers
module irpb_ctrl (
	// Clock, reset, clock enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port from the serial host logic
	input wire irpb_pkg::irpb_regreq_type reg_req,
	output logic [7:0] reg_rdata,
	// Pattern memory write port
	input wire irpb_pkg::irpb_patreq_type pat_req,
	// Mode enable
	input wire logic pattern_burst_enable,
	// LED driver
	output logic led_driver_output,
	output logic led_drive_en,
	output logic led_slew_ctrl,
	// Status
	output logic burst_done_flag,
	output logic burst_busy,
	output logic burst_irq
);
	import irpb_pkg::*;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	irpb_ctrl_type pattern_burst_control;
	logic [7:0] sym_loops, sym_off, pkt_loops, pkt_off, symbol_length_nibbles;
	logic [BT_FIELD_W-1:0] bit_time_setting;
	logic [7:0] pat_ram [0:PAT_BYTES-1];
	irpb_state_type state, next_state;
	logic [10:0] cnt, next_cnt;
	logic [9:0] bit_idx, next_bit_idx;
	logic [7:0] sym_left, next_sym_left;
	logic [7:0] pkt_left, next_pkt_left;
	logic finish, sym_end, enter, tick;
	logic next_led, next_led_en;

	// ----------------------------------------
	// Write decode and derived values
	// ----------------------------------------
	wire wr_ctrl = reg_req.wr && (reg_req.addr == ADDR_CTRL);
	wire wr_sym_loops = reg_req.wr && (reg_req.addr == ADDR_SYM_LOOPS);
	wire wr_sym_off = reg_req.wr && (reg_req.addr == ADDR_SYM_OFF);
	wire wr_pkt_loops = reg_req.wr && (reg_req.addr == ADDR_PKT_LOOPS);
	wire wr_pkt_off = reg_req.wr && (reg_req.addr == ADDR_PKT_OFF);
	wire wr_bit_time = reg_req.wr && (reg_req.addr == ADDR_BIT_TIME);
	wire wr_len = reg_req.wr && (reg_req.addr == ADDR_SYM_LEN);
	wire wr_clear = reg_req.wr && (reg_req.addr == ADDR_CLEAR);
	wire start = wr_len && pattern_burst_enable;
	irpb_ctrl_type eff_ctrl;
	assign eff_ctrl = pattern_burst_enable ? pattern_burst_control : irpb_ctrl_type'(RST_REG);
	wire qz_on = (eff_ctrl.qz_len != 3'b000);
	wire [10:0] qz_bits = (11'h002 << eff_ctrl.qz_len) + 11'h001;
	wire [9:0] last_bit = {symbol_length_nibbles, 2'b11};
	wire [10:0] sym_off_bits = {2'b00, sym_off, 1'b0} + 11'h001;
	wire [10:0] pkt_off_bits = ({3'b000, pkt_off} + 11'h001) << 2;
	wire [7:0] pat_byte = pat_ram[bit_idx[9:3]];
	wire pat_bit = pat_byte[bit_idx[2:0]];
	wire [7:0] status_val = {6'h00, burst_done_flag, burst_busy};
	wire [7:0] rd_mux = (reg_req.addr == ADDR_CTRL) ? pattern_burst_control :
		(reg_req.addr == ADDR_SYM_LOOPS) ? sym_loops :
		(reg_req.addr == ADDR_SYM_OFF) ? sym_off :
		(reg_req.addr == ADDR_PKT_LOOPS) ? pkt_loops :
		(reg_req.addr == ADDR_PKT_OFF) ? pkt_off :
		(reg_req.addr == ADDR_BIT_TIME) ? {2'b00, bit_time_setting} :
		(reg_req.addr == ADDR_SYM_LEN) ? symbol_length_nibbles :
		(reg_req.addr == ADDR_STATUS) ? status_val : RST_REG;

	// ----------------------------------------
	// Bit-time base
	// ----------------------------------------
	irpb_tick u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.restart(start),
		.bit_time_setting(bit_time_setting),
		.tick(tick)
	);

	// Configuration registers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pattern_burst_control <= irpb_ctrl_type'(RST_REG);
			sym_loops <= RST_REG;
			sym_off <= RST_REG;
			pkt_loops <= RST_REG;
			pkt_off <= RST_REG;
			bit_time_setting <= RST_REG[BT_FIELD_W-1:0];
			symbol_length_nibbles <= RST_REG;
		end else if (ce) begin
			if (wr_ctrl) pattern_burst_control <= reg_req.data;
			if (wr_sym_loops) sym_loops <= reg_req.data;
			if (wr_sym_off) sym_off <= reg_req.data;
			if (wr_pkt_loops) pkt_loops <= reg_req.data;
			if (wr_pkt_off) pkt_off <= reg_req.data;
			if (wr_bit_time) bit_time_setting <= reg_req.data[BT_FIELD_W-1:0];
			if (wr_len) symbol_length_nibbles <= reg_req.data;
		end
	end

	// Pattern memory
	always_ff @(posedge core_clk) begin
		if (ce && pat_req.wr) begin
			pat_ram[pat_req.addr] <= pat_req.data;
		end
	end

	// ----------------------------------------
	// Burst sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_bit_idx = bit_idx;
		next_sym_left = sym_left;
		next_pkt_left = pkt_left;
		finish = 1'b0;
		sym_end = 1'b0;
		enter = 1'b0;
		if (start) begin
			next_sym_left = sym_loops;
			next_pkt_left = pkt_loops;
			enter = 1'b1;
		end else if (!pattern_burst_enable) begin
			next_state = ST_IDLE;
		end else if (tick) begin
			case (state)
				ST_QZ_PRE: begin
					if (cnt > 11'h001) begin
						next_cnt = cnt - 11'h001;
					end else begin
						next_state = ST_DATA;
					end
				end
				ST_DATA: begin
					if (bit_idx != last_bit) begin
						next_bit_idx = bit_idx + 10'h001;
					end else if (qz_on) begin
						next_state = ST_QZ_POST;
						next_cnt = qz_bits;
					end else begin
						sym_end = 1'b1;
					end
				end
				ST_QZ_POST: begin
					if (cnt > 11'h001) begin
						next_cnt = cnt - 11'h001;
					end else begin
						sym_end = 1'b1;
					end
				end
				ST_SYM_OFF: begin
					if (cnt > 11'h001) begin
						next_cnt = cnt - 11'h001;
					end else begin
						next_sym_left = sym_left - 8'h01;
						enter = 1'b1;
					end
				end
				ST_PKT_OFF: begin
					if (cnt > 11'h001) begin
						next_cnt = cnt - 11'h001;
					end else begin
						next_pkt_left = pkt_left - 8'h01;
						next_sym_left = sym_loops;
						enter = 1'b1;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
		if (sym_end) begin
			if (sym_left != 8'h00) begin
				next_state = ST_SYM_OFF;
				next_cnt = sym_off_bits;
			end else if (pkt_left != 8'h00) begin
				next_state = ST_PKT_OFF;
				next_cnt = pkt_off_bits;
			end else begin
				next_state = ST_IDLE;
				finish = 1'b1;
			end
		end
		if (enter) begin
			next_state = qz_on ? ST_QZ_PRE : ST_DATA;
			next_cnt = qz_bits;
			next_bit_idx = 10'h000;
		end
	end

	// LED level and drive for the current bit-time
	always_comb begin
		next_led = 1'b0;
		next_led_en = 1'b0;
		case (state)
			ST_QZ_PRE, ST_QZ_POST: begin
				next_led = eff_ctrl.qz_level;
				next_led_en = 1'b1;
			end
			ST_DATA: begin
				next_led = pat_bit;
				next_led_en = pat_bit || (qz_on && eff_ctrl.qz_level);
			end
			default: next_led_en = 1'b0;
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			cnt <= 11'h000;
			bit_idx <= 10'h000;
			sym_left <= RST_REG;
			pkt_left <= RST_REG;
		end else if (ce) begin
			state <= next_state;
			cnt <= next_cnt;
			bit_idx <= next_bit_idx;
			sym_left <= next_sym_left;
			pkt_left <= next_pkt_left;
		end
	end

	// ----------------------------------------
	// Outputs and status
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= RST_REG;
			led_driver_output <= 1'b0;
			led_drive_en <= 1'b0;
			led_slew_ctrl <= 1'b0;
			burst_done_flag <= 1'b0;
			burst_busy <= 1'b0;
			burst_irq <= 1'b0;
		end else if (ce) begin
			reg_rdata <= rd_mux;
			led_driver_output <= next_led;
			led_drive_en <= next_led_en;
			led_slew_ctrl <= eff_ctrl.slew;
			burst_done_flag <= finish || (burst_done_flag && !wr_clear);
			burst_busy <= (next_state != ST_IDLE);
			burst_irq <= burst_done_flag && eff_ctrl.irq_en;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_cfg_gated_off: assert property ((ce && !pattern_burst_enable) |=> state == ST_IDLE)
		else $error("engine runs while burst mode disabled");
	a_irq_mask_off: assert property ((ce && !eff_ctrl.irq_en) |=> !burst_irq)
		else $error("interrupt raised while masked");
	a_irq_follows_done: assert property ((ce && burst_done_flag && eff_ctrl.irq_en) |=> burst_irq)
		else $error("interrupt missing after completion");
	a_zero_bit_low: assert property ((ce && state == ST_DATA && !pat_bit && qz_on
		&& eff_ctrl.qz_level) |=> (led_drive_en && !led_driver_output))
		else $error("zero bit not driven low");
	a_qz_level_held: assert property ((ce && (state == ST_QZ_PRE || state == ST_QZ_POST))
		|=> (led_drive_en && led_driver_output == $past(eff_ctrl.qz_level)))
		else $error("quiet zone level wrong");
	a_qz_length_load: assert property ((ce && start && qz_on)
		|=> (state == ST_QZ_PRE && cnt == $past(qz_bits)))
		else $error("quiet zone length not loaded");
	a_start_busy: assert property ((ce && start) |=> burst_busy)
		else $error("busy not raised after start");
	a_done_sticky: assert property ((burst_done_flag && !(ce && wr_clear)) |=> burst_done_flag)
		else $error("completion flag lost");
	a_no_qz_undriven: assert property ((ce && state == ST_DATA && !pat_bit && !qz_on)
		|=> !led_drive_en)
		else $error("level bit acted without quiet zone");

	c_burst_done: cover property (finish);
	c_symbol_gap: cover property (state == ST_SYM_OFF);
	c_packet_gap: cover property (state == ST_PKT_OFF);
	c_irq_raised: cover property (burst_irq);

endmodule : irpb_ctrl

// ===== rtl/irpb_pkg.sv
// Package of constants and types for the pattern-burst control block
package irpb_pkg;

	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'hA0;
	localparam logic [7:0] ADDR_SYM_LOOPS = 8'hA2;
	localparam logic [7:0] ADDR_SYM_OFF = 8'hA3;
	localparam logic [7:0] ADDR_PKT_LOOPS = 8'hA4;
	localparam logic [7:0] ADDR_PKT_OFF = 8'hA5;
	localparam logic [7:0] ADDR_BIT_TIME = 8'hA6;
	localparam logic [7:0] ADDR_SYM_LEN = 8'hA7;
	localparam logic [7:0] ADDR_STATUS = 8'hA8;
	localparam logic [7:0] ADDR_CLEAR = 8'hAA;

	// ----------------------------------------
	// Reset values and field positions
	// ----------------------------------------
	localparam logic [7:0] RST_REG = 8'h00;
	localparam int STATUS_DONE_BIT = 1;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int BT_FIELD_W = 6;
	localparam int PAT_BYTES = 128;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int BIT_BASE_NS = 270; // One bit-time unit, 0.27 us
	localparam int CLK_NS = 5;
	localparam int BIT_BASE_CYC = (BIT_BASE_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] reserved;
		logic irq_en;
		logic slew;
		logic qz_level;
		logic [2:0] qz_len;
	} irpb_ctrl_type;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} irpb_regreq_type;

	typedef struct packed {
		logic wr;
		logic [6:0] addr;
		logic [7:0] data;
	} irpb_patreq_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_QZ_PRE = 3'b001,
		ST_DATA = 3'b010,
		ST_QZ_POST = 3'b011,
		ST_SYM_OFF = 3'b100,
		ST_PKT_OFF = 3'b101
	} irpb_state_type;

endpackage : irpb_pkg

// ===== rtl/irpb_tick.sv
// Bit-time tick generator for the pattern-burst engine
module irpb_tick (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic restart,
	input wire logic [irpb_pkg::BT_FIELD_W-1:0] bit_time_setting,
	// Tick out
	output logic tick
);
	import irpb_pkg::*;

	logic [11:0] cnt;
	wire [11:0] period_cyc = ({6'h00, bit_time_setting} + 12'h001) * 12'(BIT_BASE_CYC);

	// One tick per bit-time, phase restarted by a new burst
	assign tick = (cnt == 12'h000) && !restart;

	// ----------------------------------------
	// Down counter
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt <= 12'h000;
		end else if (ce) begin
			if (restart || cnt == 12'h000) begin
				cnt <= period_cyc - 12'h001;
			end else begin
				cnt <= cnt - 12'h001;
			end
		end
	end

	a_bit_period: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && tick) |=> (cnt == $past(period_cyc) - 12'h001))
		else $error("bit-time period not reloaded");

endmodule : irpb_tick

// ===== sim/irpb_ctrl_tb.sv
// Self-checking testbench for the pattern-burst engine
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("mismatch %s expected %0h seen %0h", nm, e, g); \
	end \
end
module irpb_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import irpb_pkg::*;

	logic core_clk, rst_n, ce, pattern_burst_enable;
	irpb_regreq_type reg_req;
	irpb_patreq_type pat_req;
	logic [7:0] reg_rdata;
	logic led_driver_output, led_drive_en, led_slew_ctrl;
	logic burst_done_flag, burst_busy, burst_irq;
	int n_fail = 0;
	int num_checks = 0;
	logic [1:0] exp_q[$];

	// ----------------------------------------
	// Design and LED receiver
	// ----------------------------------------
	irpb_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .pat_req(pat_req), .pattern_burst_enable(pattern_burst_enable),
		.led_driver_output(led_driver_output), .led_drive_en(led_drive_en),
		.led_slew_ctrl(led_slew_ctrl), .burst_done_flag(burst_done_flag),
		.burst_busy(burst_busy), .burst_irq(burst_irq));
	irpb_scanner_model scan (.core_clk(core_clk), .led_driver_output(led_driver_output),
		.led_drive_en(led_drive_en), .burst_busy(burst_busy));

	// Clock, 5 ns period
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_req <= '{wr: 1'b1, addr: a, data: d};
		@(negedge core_clk);
		reg_req.wr <= 1'b0;
	endtask : wr

	task automatic chkrd(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(negedge core_clk);
		reg_req.addr <= a;
		@(negedge core_clk);
		`CHK(nm, e, reg_rdata)
	endtask : chkrd

	task automatic pw(input logic [6:0] a, input logic [7:0] d);
		@(negedge core_clk);
		pat_req <= '{wr: 1'b1, addr: a, data: d};
		@(negedge core_clk);
		pat_req.wr <= 1'b0;
	endtask : pw

	// Bounded wait for the busy flag to reach a level
	task automatic wait_busy(input logic v);
		int i;
		for (i = 0; i < 20000 && burst_busy !== v; i++) @(negedge core_clk);
		if (burst_busy !== v) begin
			n_fail++;
			finish_test();
		end
	endtask : wait_busy

	// One burst of 4*(ln+1)-bit symbols from pattern byte p, LED compared cycle by cycle
	// Symbols of 4*(ln+1) bits, lp+1 symbols per packet and lp+1 packets,
	// symbol gap 3 bit-times and packet gap 8 bit-times (offset registers at 1)
	task automatic burst(input logic [7:0] c, input logic [5:0] bt, input logic [7:0] p,
		input logic [7:0] ln, input logic [7:0] lp);
		int bc;
		int q;
		int k;
		int pk;
		int sy;
		irpb_ctrl_type cf;
		cf = c;
		bc = (bt + 1) * BIT_BASE_CYC;
		q = (cf.qz_len != 3'b000) ? (2 << cf.qz_len) + 1 : 0;
		exp_q.delete();
		for (pk = 0; pk <= lp; pk++) begin
			for (sy = 0; sy <= lp; sy++) begin
				repeat (q * bc) exp_q.push_back({1'b1, cf.qz_level});
				for (k = 0; k < 4 * (ln + 1); k++) begin
					repeat (bc) exp_q.push_back(p[k] ? 2'b11 : (cf.qz_level && q != 0) ? 2'b10 : 2'b00);
				end
				repeat (q * bc) exp_q.push_back({1'b1, cf.qz_level});
				if (sy < lp) repeat (3 * bc) exp_q.push_back(2'b00);
			end
			if (pk < lp) repeat (8 * bc) exp_q.push_back(2'b00);
		end
		pw(7'h00, p);
		wr(ADDR_SYM_LOOPS, lp);
		wr(ADDR_PKT_LOOPS, lp);
		wr(ADDR_SYM_OFF, 8'h01);
		wr(ADDR_PKT_OFF, 8'h01);
		wr(ADDR_CTRL, c);
		wr(ADDR_BIT_TIME, {2'b00, bt});
		scan.seg.delete();
		wr(ADDR_SYM_LEN, ln);
		wait_busy(1'b1);
		chkrd(ADDR_STATUS, 8'h01, "status_busy");
		wait_busy(1'b0);
		// Let the receiver log the final LED sample before comparing
		@(posedge core_clk);
		for (k = 0; k < exp_q.size() && k < scan.seg.size() && exp_q[k] === scan.seg[k]; k++);
		`CHK("led_len", exp_q.size(), scan.seg.size())
		`CHK("led_wave_first_diff", exp_q.size(), k)
		chkrd(ADDR_STATUS, 8'h02, "status_done");
		`CHK("done_pin", 1'b1, burst_done_flag)
		`CHK("irq", cf.irq_en, burst_irq)
		wr(ADDR_CLEAR, 8'h00);
		chkrd(ADDR_STATUS, 8'h00, "status_cleared");
		`CHK("irq_cleared", 1'b0, burst_irq)
	endtask : burst

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		static logic [7:0] regs[10] = '{ADDR_CTRL, ADDR_SYM_LOOPS, ADDR_SYM_OFF, ADDR_PKT_LOOPS,
			ADDR_PKT_OFF, ADDR_BIT_TIME, ADDR_SYM_LEN, ADDR_STATUS, ADDR_CLEAR, 8'h10};
		rst_n = 1'b0;
		ce = 1'b1;
		pattern_burst_enable = 1'b0;
		reg_req = '0;
		pat_req = '0;
		repeat (16) @(negedge core_clk);
		rst_n <= 1'b1;
		foreach (regs[i]) chkrd(regs[i], RST_REG, "reset_value");
		`CHK("busy_reset", 1'b0, burst_busy)
		pattern_burst_enable <= 1'b1;
		for (int i = 1; i < 5; i++) begin
			wr(regs[i], 8'h3C);
			chkrd(regs[i], 8'h3C, "readback");
			wr(regs[i], 8'h00);
		end
		// A write while the clock enable is low must leave no trace
		ce <= 1'b0;
		wr(ADDR_SYM_LOOPS, 8'h3C);
		ce <= 1'b1;
		chkrd(ADDR_SYM_LOOPS, 8'h00, "frozen_write");
		wr(ADDR_STATUS, 8'hFF);
		chkrd(ADDR_STATUS, 8'h00, "status_read_only");
		wr(ADDR_CTRL, 8'h10);
		@(negedge core_clk);
		`CHK("slew_on", 1'b1, led_slew_ctrl)
		pattern_burst_enable <= 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK("slew_mode_off", 1'b0, led_slew_ctrl)
		wr(ADDR_SYM_LEN, 8'h00);
		repeat (4) @(negedge core_clk);
		`CHK("no_start_mode_off", 1'b0, burst_busy)
		pattern_burst_enable <= 1'b1;
		burst(8'h29, 6'h00, 8'hA5, 8'h00, 8'h00);
		burst(8'h01, 6'h00, 8'h5A, 8'h00, 8'h00);
		burst(8'h08, 6'h01, 8'hC3, 8'h00, 8'h00);
		burst(8'h0A, 6'h00, 8'h96, 8'h00, 8'h00);
		burst(8'h09, 6'h00, 8'h3C, 8'h01, 8'h01);
		// Abort a long burst by dropping the mode enable
		wr(ADDR_CTRL, 8'h07);
		wr(ADDR_SYM_LEN, 8'h00);
		wait_busy(1'b1);
		pattern_burst_enable <= 1'b0;
		wait_busy(1'b0);
		chkrd(ADDR_STATUS, 8'h00, "status_after_abort");
		finish_test();
	end
endmodule : irpb_ctrl_tb

// ===== sim/irpb_scanner_model.sv
// LED-side receiver model that logs the LED line once per cycle during a burst
module irpb_scanner_model (
	// Clock
	input wire logic core_clk,
	// LED line and burst status
	input wire logic led_driver_output,
	input wire logic led_drive_en,
	input wire logic burst_busy
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] seg[$];
	logic busy_d = 1'b0;

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	// Sample on the falling edge so the registered outputs have settled;
	// the LED outputs trail busy by one cycle, so a delayed busy gates capture;
	// an undriven line reads as dark, since the level there is meaningless
	always @(negedge core_clk) begin
		if (busy_d === 1'b1) begin
			seg.push_back({led_drive_en, led_drive_en & led_driver_output});
		end
		busy_d <= burst_busy;
	end
endmodule : irpb_scanner_model
